// File: hw/cpu_pipeline_cycle_timing.sv
`include "cpu_timing_defines.svh"

module cpu_pipeline_cycle_timing
  import cpu_timing_pkg::*;
#(
  parameter bit DSP_VARIANT = 1'b0,
  parameter int CNT_W       = 4
) (
  input  wire logic    clock_i,
  input  wire logic    rstn_i,
  input  wire logic    issue_valid_i,
  input  wire iclass_t issue_class_i,
  input  wire logic    branch_taken_i,
  input  wire logic    fetch_req_i,
  input  wire logic    mult_busy_i,
  input  wire logic    load_use_i,
  input  wire logic    wake_i,
  output logic         issue_ready_o,
  output logic         stall_o,
  output logic         fetch_grant_o,
  output logic         ma_grant_o,
  output logic         commit_o,
  output iclass_t      commit_class_o,
  output logic [3:0]   stages_o,
  output logic [3:0]   cycles_used_o,
  output logic         halted_o
);

  if (CNT_W < 4) begin : g_width_check
    $error("CNT_W must be at least 4");
  end

  // ----------------------------------------
  // Class timing tables
  // ----------------------------------------
  function automatic logic [3:0] base_cycles(input iclass_t c, input logic taken);
    unique case (c)
      ic_reg_op:                            base_cycles = `CYC_REG_OP;
      ic_branch:                            base_cycles = `CYC_BRANCH;
      ic_cond_branch:
        base_cycles = taken ? `CYC_COND_TAKEN : `CYC_COND_NOT;
      ic_cond_branch_delayed:
        base_cycles = taken ? `CYC_DELAY_TAKEN : `CYC_DELAY_NOT;
      ic_halt:                              base_cycles = `CYC_HALT;
      ic_exception_return_instruction:      base_cycles = `CYC_EXC_RETURN;
      ic_status_register_load_reg:          base_cycles = `CYC_STATUS_REG;
      ic_status_register_load_mem:          base_cycles = `CYC_STATUS_MEM;
      ic_trap:
        base_cycles = DSP_VARIANT ? `CYC_TRAP_DSP : `CYC_TRAP;
      ic_bank_store_predec:                 base_cycles = `CYC_BANK_STORE;
      ic_mem_logic:                         base_cycles = `CYC_MEM_LOGIC;
      ic_atomic_test_and_set:
        base_cycles = DSP_VARIANT ? `CYC_TEST_SET_DSP : `CYC_TEST_SET;
      ic_control_register_load_from_memory:
        base_cycles = DSP_VARIANT ? `CYC_CTRL_MEM_DSP : `CYC_CTRL_MEM;
      ic_multiply:                          base_cycles = `CYC_MUL;
      ic_multiply_accumulator_single,
      ic_multiply_double,
      ic_multiply_accumulator_double:       base_cycles = `CYC_MAC;
      ic_accumulator_to_reg:                base_cycles = `CYC_DSP_TO_REG;
      default:                              base_cycles = `CYC_REG_OP;
    endcase
  endfunction

  function automatic logic [3:0] class_stages(input iclass_t c);
    unique case (c)
      ic_exception_return_instruction,
      ic_status_register_load_reg,
      ic_bank_store_predec,
      ic_control_register_load_from_memory,
      ic_accumulator_to_reg:                class_stages = `STG_FIVE;
      ic_status_register_load_mem,
      ic_multiply_accumulator_single:       class_stages = `STG_SEVEN;
      ic_trap,
      ic_multiply_double,
      ic_multiply_accumulator_double:       class_stages = `STG_NINE;
      ic_mem_logic,
      ic_atomic_test_and_set,
      ic_multiply:                          class_stages = `STG_SIX;
      default:                              class_stages = `STG_THREE;
    endcase
  endfunction

  // Used count at which multiplier contention stops holding the instruction; zero for non-multiplier work
  function automatic logic [3:0] mult_limit(input iclass_t c);
    unique case (c)
      ic_multiply:                          mult_limit = `CYC_MUL_MAX;
      ic_multiply_accumulator_single,
      ic_multiply_double,
      ic_multiply_accumulator_double:       mult_limit = `CYC_MAC_MAX;
      default:                              mult_limit = `CNT_ZERO;
    endcase
  endfunction

  function automatic logic uses_memory_access(input iclass_t c);
    unique case (c)
      ic_status_register_load_mem,
      ic_bank_store_predec,
      ic_mem_logic,
      ic_atomic_test_and_set,
      ic_control_register_load_from_memory,
      ic_multiply,
      ic_multiply_accumulator_single,
      ic_multiply_double,
      ic_multiply_accumulator_double,
      ic_accumulator_to_reg:                uses_memory_access = 1'b1;
      default:                              uses_memory_access = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Issue state
  // ----------------------------------------
  issue_state_t state;
  iclass_t      cur_class;
  logic [3:0]   remaining;
  logic [3:0]   used;
  logic [3:0]   limit;
  logic         use_stall_done;
  logic         finishing;
  logic         accept;
  logic         ma_req;
  logic         mult_req;
  logic         mult_room;
  logic         arb_hold;
  logic         use_hold;
  logic         hold;

  assign finishing = (state == st_busy) && (remaining == `CNT_ONE);
  assign ma_req    = finishing && uses_memory_access(cur_class);
  assign mult_req  = (state == st_busy) && (limit != `CNT_ZERO);
  assign mult_room = (used < limit);
  // A dependent follower of a control load waits once for the loaded value
  assign use_hold  = finishing && load_use_i && !use_stall_done &&
                     (cur_class == ic_control_register_load_from_memory);
  assign hold      = arb_hold || use_hold;
  assign stall_o   = hold;
  // Younger work is only taken when the current one leaves this cycle
  assign issue_ready_o = (state == st_idle) || (finishing && !hold);
  assign accept        = issue_valid_i && issue_ready_o;

  memory_access_arbiter u_arbiter (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .ma_req_i      (ma_req),
    .fetch_req_i   (fetch_req_i),
    .mult_req_i    (mult_req),
    .mult_busy_i   (mult_busy_i),
    .mult_room_i   (mult_room),
    .fetch_grant_o (fetch_grant_o),
    .ma_grant_o    (ma_grant_o),
    .hold_o        (arb_hold)
  );

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (accept) begin
            state <= st_busy;
          end
        end
        st_busy: begin
          if (finishing && !hold) begin
            if (cur_class == ic_halt) begin
              state <= st_halted;
            end else if (!accept) begin
              state <= st_idle;
            end
          end
        end
        st_halted: begin
          if (wake_i) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Cycle counting
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      remaining      <= `CNT_ZERO;
      used           <= `CNT_ZERO;
      limit          <= `CNT_ZERO;
      cur_class      <= ic_reg_op;
      use_stall_done <= 1'b0;
    end else if (accept && !(finishing && cur_class == ic_halt)) begin
      remaining      <= base_cycles(issue_class_i, branch_taken_i);
      used           <= `CNT_ONE;
      limit          <= mult_limit(issue_class_i);
      cur_class      <= issue_class_i;
      use_stall_done <= 1'b0;
    end else if (state == st_busy) begin
      used <= used + `CNT_ONE;
      if (use_hold) begin
        use_stall_done <= 1'b1;
      end
      // A held instruction keeps its place; only progress counts down
      if (!hold && remaining != `CNT_ZERO) begin
        remaining <= remaining - `CNT_ONE;
      end
    end
  end

  // ----------------------------------------
  // Completion report
  // ----------------------------------------
  // Results become visible only once every added cycle is spent
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      commit_o       <= 1'b0;
      commit_class_o <= ic_reg_op;
      stages_o       <= `CNT_ZERO;
      cycles_used_o  <= `CNT_ZERO;
    end else begin
      commit_o <= finishing && !hold;
      if (finishing && !hold) begin
        commit_class_o <= cur_class;
        stages_o       <= class_stages(cur_class);
        cycles_used_o  <= used;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      halted_o <= 1'b0;
    end else begin
      halted_o <= (state == st_halted) && !wake_i;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence take_s(iclass_t c);
    accept && issue_class_i == c;
  endsequence

  sequence done_after_s(int n);
    (!commit_o) [*1] ##(n - 1) commit_o;
  endsequence

  reg_op_timing_a: assert property (
    take_s(ic_reg_op) |-> ##2 commit_o && stages_o == `STG_THREE && cycles_used_o == `CYC_REG_OP
  ) else $error("register operation not one cycle");

  branch_timing_a: assert property (
    take_s(ic_branch) |-> ##2 !commit_o ##1 commit_o && stages_o == `STG_THREE
  ) else $error("branch not two cycles");

  cond_branch_a: assert property (
    accept && issue_class_i == ic_cond_branch && branch_taken_i
      |-> ##2 (!commit_o) [*2] ##1 commit_o
  ) else $error("taken branch not three cycles");

  delayed_branch_a: assert property (
    accept && issue_class_i == ic_cond_branch_delayed && !branch_taken_i |-> ##2 commit_o
  ) else $error("untaken delayed branch not one cycle");

  halt_entry_a: assert property (
    take_s(ic_halt) |-> ##2 (!commit_o) [*3] ##1 (commit_o && !issue_ready_o)
      ##1 (halted_o || $past(wake_i))
  ) else $error("halt not four cycles");

  exc_return_a: assert property (
    take_s(ic_exception_return_instruction)
      |-> ##2 (!commit_o) [*3] ##1 commit_o && stages_o == `STG_FIVE
  ) else $error("exception return timing wrong");

  status_reg_load_a: assert property (
    commit_o && commit_class_o == ic_status_register_load_reg
      |-> cycles_used_o == `CYC_STATUS_REG && stages_o == `STG_FIVE
  ) else $error("status load from register timing wrong");

  trap_cycles_a: assert property (
    commit_o && commit_class_o == ic_trap |-> stages_o == `STG_NINE &&
      cycles_used_o == (DSP_VARIANT ? `CYC_TRAP_DSP : `CYC_TRAP)
  ) else $error("trap timing wrong");

  multiply_bound_a: assert property (
    commit_o && commit_class_o == ic_multiply
      |-> cycles_used_o <= `CYC_MUL_MAX + `CNT_ONE && stages_o == `STG_SIX
  ) else $error("multiply stretched too far");

  stall_holds_a: assert property (
    stall_o |-> !issue_ready_o ##1 (!commit_o && $stable(remaining) && $stable(cur_class))
  ) else $error("stalled instruction advanced");

endmodule

// File: hw/cpu_timing_defines.svh
`ifndef CPU_TIMING_DEFINES_SVH
`define CPU_TIMING_DEFINES_SVH

// Execution cycles per instruction class
`define CYC_REG_OP        4'h1
`define CYC_BRANCH        4'h2
`define CYC_COND_TAKEN    4'h3
`define CYC_COND_NOT      4'h1
`define CYC_DELAY_TAKEN   4'h2
`define CYC_DELAY_NOT     4'h1
`define CYC_HALT          4'h4
`define CYC_EXC_RETURN    4'h4
`define CYC_STATUS_REG    4'h5
`define CYC_STATUS_MEM    4'h7
`define CYC_TRAP          4'h6
`define CYC_TRAP_DSP      4'h8
`define CYC_BANK_STORE    4'h2
`define CYC_MEM_LOGIC     4'h3
`define CYC_TEST_SET      4'h3
`define CYC_TEST_SET_DSP  4'h4
`define CYC_CTRL_MEM      4'h1
`define CYC_CTRL_MEM_DSP  4'h5
`define CYC_MUL           4'h1
`define CYC_MUL_MAX       4'h3
`define CYC_MAC           4'h2
`define CYC_MAC_MAX       4'h5
`define CYC_DSP_TO_REG    4'h1

// Pipeline stages per instruction class
`define STG_THREE         4'h3
`define STG_FIVE          4'h5
`define STG_SIX           4'h6
`define STG_SEVEN         4'h7
`define STG_NINE          4'h9

`define CNT_ZERO          4'h0
`define CNT_ONE           4'h1

`endif

// File: hw/cpu_timing_pkg.sv
package cpu_timing_pkg;

  typedef enum logic [4:0] {
    ic_reg_op,
    ic_branch,
    ic_cond_branch,
    ic_cond_branch_delayed,
    ic_halt,
    ic_exception_return_instruction,
    ic_status_register_load_reg,
    ic_status_register_load_mem,
    ic_trap,
    ic_bank_store_predec,
    ic_mem_logic,
    ic_atomic_test_and_set,
    ic_control_register_load_from_memory,
    ic_multiply,
    ic_multiply_accumulator_single,
    ic_multiply_double,
    ic_multiply_accumulator_double,
    ic_accumulator_to_reg
  } iclass_t;

  typedef enum {
    st_idle,
    st_busy,
    st_halted
  } issue_state_t;

endpackage

// File: hw/memory_access_arbiter.sv
`include "cpu_timing_defines.svh"

module memory_access_arbiter (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic ma_req_i,
  input  wire logic fetch_req_i,
  input  wire logic mult_req_i,
  input  wire logic mult_busy_i,
  input  wire logic mult_room_i,
  output logic      fetch_grant_o,
  output logic      ma_grant_o,
  output logic      hold_o
);

  // ----------------------------------------
  // Fetch versus memory access
  // ----------------------------------------
  // Fetch wins the first clash; the access then wins the next cycle, so a
  // clash costs exactly one cycle and a stream of fetches cannot starve it.
  logic ma_lost;
  logic ma_hold;
  logic mult_hold;

  assign ma_hold       = ma_req_i && fetch_req_i && !ma_lost;
  assign mult_hold     = mult_req_i && mult_busy_i && mult_room_i;
  assign hold_o        = ma_hold || mult_hold;
  assign fetch_grant_o = fetch_req_i && !(ma_req_i && ma_lost);
  assign ma_grant_o    = ma_req_i && !hold_o;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ma_lost <= 1'b0;
    end else if (ma_grant_o) begin
      ma_lost <= 1'b0;
    end else if (ma_hold) begin
      ma_lost <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  clash_adds_cycle_a: assert property (
    (ma_req_i && fetch_req_i && !ma_lost) |-> (hold_o && !ma_grant_o && fetch_grant_o)
  ) else $error("memory access ran beside a fetch");

  no_double_grant_a: assert property (
    !(ma_grant_o && fetch_grant_o)
  ) else $error("fetch and memory access granted together");

endmodule

// File: testbench/far_side_model.sv
// ----------------------------------------------------------------
// Fetch path, multiplier neighbour and load-use source
// ----------------------------------------------------------------
module far_side_model (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic fetch_on_i,
  input  wire logic mult_on_i,
  input  wire logic use_on_i,
  output logic      fetch_req_o,
  output logic      mult_busy_o,
  output logic      load_use_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Requests move just after the edge, like any other port driver
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      fetch_req_o <= #1 1'b0;
      mult_busy_o <= #1 1'b0;
      load_use_o  <= #1 1'b0;
    end else begin
      fetch_req_o <= #1 fetch_on_i;
      mult_busy_o <= #1 mult_on_i;
      load_use_o  <= #1 use_on_i;
    end
  end
endmodule

// File: testbench/tb_top.sv
module tb_top
  import cpu_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       issue_valid = 1'b0;
  iclass_t    issue_class = ic_reg_op;
  logic       branch_taken = 1'b0;
  logic       fetch_on = 1'b0;
  logic       mult_on = 1'b0;
  logic       use_on = 1'b0;
  logic       wake = 1'b0;
  logic       fetch_req, mult_busy, load_use;
  logic       issue_ready_o, stall_o, fetch_grant_o, ma_grant_o, commit_o, halted_o;
  iclass_t    commit_class_o;
  logic [3:0] stages_o, cycles_used_o;
  logic       s1, f1, m1, f2, m2;
  int         err_count = 0;
  int         n_checks = 0;
  int         cyc = 0;

  always #5 clock_i = ~clock_i;

  far_side_model far_side_model_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .fetch_on_i(fetch_on), .mult_on_i(mult_on),
    .use_on_i(use_on), .fetch_req_o(fetch_req), .mult_busy_o(mult_busy),
    .load_use_o(load_use));

  cpu_pipeline_cycle_timing cpu_pipeline_cycle_timing_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid),
    .issue_class_i(issue_class), .branch_taken_i(branch_taken), .fetch_req_i(fetch_req),
    .mult_busy_i(mult_busy), .load_use_i(load_use), .wake_i(wake),
    .issue_ready_o(issue_ready_o), .stall_o(stall_o), .fetch_grant_o(fetch_grant_o),
    .ma_grant_o(ma_grant_o), .commit_o(commit_o), .commit_class_o(commit_class_o),
    .stages_o(stages_o), .cycles_used_o(cycles_used_o), .halted_o(halted_o));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
    end
  endtask

  task automatic check_val(input logic [3:0] got, input logic [3:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded so a lost commit shows up as a latency mismatch, not a hang
  task automatic run_one(input iclass_t cls, input logic taken, output logic [3:0] lat);
    int n;
    n = 0;
    @(posedge clock_i);
    #1;
    issue_valid = 1'b1;
    issue_class = cls;
    branch_taken = taken;
    @(negedge clock_i);
    while (issue_ready_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    @(posedge clock_i);
    #1;
    issue_valid = 1'b0;
    n = 1;
    @(negedge clock_i);
    {s1, f1, m1} = {stall_o, fetch_grant_o, ma_grant_o};
    while (commit_o !== 1'b1 && n < 15) begin
      @(negedge clock_i);
      if (n == 1) {f2, m2} = {fetch_grant_o, ma_grant_o};
      n++;
    end
    lat = 4'(n);
  endtask

  task automatic exp_run(input iclass_t cls, input logic taken, input logic [3:0] cyc_e,
                         input logic [3:0] stg_e);
    logic [3:0] lat;
    run_one(cls, taken, lat);
    check_val(lat, cyc_e + 4'h1, "commit latency");
    check_val(cycles_used_o, cyc_e, "cycles used");
    check_val(stages_o, stg_e, "stages");
    check_bit(commit_class_o == cls, 1'b1, "commit class");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check_bit(issue_ready_o, 1'b1, "ready after reset");
    check_bit(stall_o | commit_o | halted_o, 1'b0, "idle flags after reset");
    check_val(cycles_used_o | stages_o, 4'h0, "counts after reset");
    $display("test reset done");
  endtask

  task automatic test_base();
    exp_run(ic_reg_op, 1'b0, 4'h1, 4'h3);
    exp_run(ic_branch, 1'b0, 4'h2, 4'h3);
    exp_run(ic_cond_branch, 1'b1, 4'h3, 4'h3);
    exp_run(ic_cond_branch, 1'b0, 4'h1, 4'h3);
    exp_run(ic_cond_branch_delayed, 1'b1, 4'h2, 4'h3);
    exp_run(ic_cond_branch_delayed, 1'b0, 4'h1, 4'h3);
    exp_run(ic_exception_return_instruction, 1'b0, 4'h4, 4'h5);
    exp_run(ic_status_register_load_reg, 1'b0, 4'h5, 4'h5);
    exp_run(ic_status_register_load_mem, 1'b0, 4'h7, 4'h7);
    exp_run(ic_trap, 1'b0, 4'h6, 4'h9);
    exp_run(ic_bank_store_predec, 1'b0, 4'h2, 4'h5);
    exp_run(ic_mem_logic, 1'b0, 4'h3, 4'h6);
    exp_run(ic_atomic_test_and_set, 1'b0, 4'h3, 4'h6);
    exp_run(ic_control_register_load_from_memory, 1'b0, 4'h1, 4'h5);
    exp_run(ic_multiply, 1'b0, 4'h1, 4'h6);
    exp_run(ic_multiply_accumulator_single, 1'b0, 4'h2, 4'h7);
    exp_run(ic_multiply_double, 1'b0, 4'h2, 4'h9);
    exp_run(ic_multiply_accumulator_double, 1'b0, 4'h2, 4'h9);
    exp_run(ic_accumulator_to_reg, 1'b0, 4'h1, 4'h5);
    $display("test base cycles done");
  endtask

  task automatic test_fetch_clash();
    @(posedge clock_i);
    #1;
    fetch_on = 1'b1;
    exp_run(ic_control_register_load_from_memory, 1'b0, 4'h2, 4'h5);
    check_bit(s1 & f1 & ~m1, 1'b1, "fetch wins first clash");
    check_bit(m2 & ~f2, 1'b1, "access wins second clash");
    exp_run(ic_bank_store_predec, 1'b0, 4'h3, 4'h5);
    exp_run(ic_status_register_load_mem, 1'b0, 4'h8, 4'h7);
    exp_run(ic_accumulator_to_reg, 1'b0, 4'h2, 4'h5);
    fetch_on = 1'b0;
    $display("test fetch clash done");
  endtask

  task automatic test_mult_clash();
    logic [3:0] lat;
    @(posedge clock_i);
    #1;
    mult_on = 1'b1;
    // The hold limit counts the hold cycle, so one extra cycle is tolerated
    run_one(ic_multiply, 1'b0, lat);
    check_bit(cycles_used_o inside {4'h3, 4'h4}, 1'b1, "multiply hold");
    check_val(lat, cycles_used_o + 4'h1, "multiply latency");
    run_one(ic_multiply_accumulator_single, 1'b0, lat);
    check_bit(cycles_used_o inside {4'h5, 4'h6}, 1'b1, "mac hold");
    run_one(ic_multiply_double, 1'b0, lat);
    check_bit(cycles_used_o inside {4'h5, 4'h6}, 1'b1, "double hold");
    mult_on = 1'b0;
    use_on = 1'b1;
    exp_run(ic_control_register_load_from_memory, 1'b0, 4'h2, 4'h5);
    use_on = 1'b0;
    $display("test multiplier and load use done");
  endtask

  task automatic test_halt();
    exp_run(ic_halt, 1'b0, 4'h4, 4'h3);
    @(negedge clock_i);
    check_bit(halted_o, 1'b1, "halted after halt");
    check_bit(issue_ready_o, 1'b0, "no issue while halted");
    @(posedge clock_i);
    #1;
    wake = 1'b1;
    @(posedge clock_i);
    #1;
    wake = 1'b0;
    repeat (2) @(negedge clock_i);
    check_bit(halted_o | ~issue_ready_o, 1'b0, "wake returns to idle");
    $display("test halt done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("unexpected at %0t: run timed out", $time);
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    @(negedge clock_i);
    test_reset();
    test_base();
    test_fetch_clash();
    test_mult_clash();
    test_halt();
    finish_test();
  end
endmodule
